// File: include/analog_status_monitor_pkg.sv
// Function
// - Power byte bit 7: charge pump, 0 powered down, 1 active.
// - Power byte bit 6: analog reference, 0 powered down, 1 active.
// - Power byte bits 5,4,3: line driver, line bias, line feedback power.
// - Power byte bits 2,1: left and right output stage power.
// - Power byte bit 0: DAC, 0 powered down, 1 active.
// - Bias byte bits 7,6: offset compensator and short protector power.
// - Bias byte bits 5,4: impedance sensor and whole impedance circuitry power.
// - Bias byte bits 3,2: left and right short protector, 0 in reset.
// - Bias byte bits 1,0: modulator and element matching, 0 in reset.
// - Mute byte bits 5,4: left and right dummy outputs, 0 muted.
// - Mute byte bits 1,0: left and right channels, 0 muted.
// - Short byte bit 4: live line output short indication.
// - Short byte bit 0: sticky short flag, set on short, cleared by read.
package analog_status_monitor_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MUTE_W = 4;
  localparam int SAMPLE_W = 2 * DATA_W + MUTE_W + 1;

  localparam logic [ADDR_W-1:0] ADDR_POWER = 8'h6A;
  localparam logic [ADDR_W-1:0] ADDR_BIAS  = 8'h6B;
  localparam logic [ADDR_W-1:0] ADDR_MUTE  = 8'h6C;
  localparam logic [ADDR_W-1:0] ADDR_SHORT = 8'h6D;

  // Register select, one-hot
  localparam int SEL_POWER = 0;
  localparam int SEL_BIAS  = 1;
  localparam int SEL_MUTE  = 2;
  localparam int SEL_SHORT = 3;
  localparam int SEL_W     = 4;

  localparam int BIT_CP    = 7;
  localparam int BIT_REF   = 6;
  localparam int BIT_LDRV  = 5;
  localparam int BIT_LBIAS = 4;
  localparam int BIT_LFB   = 3;
  localparam int BIT_LOUT  = 2;
  localparam int BIT_ROUT  = 1;
  localparam int BIT_DAC   = 0;

  localparam int BIT_OFS   = 7;
  localparam int BIT_SPROT = 6;
  localparam int BIT_IMPS  = 5;
  localparam int BIT_IMPW  = 4;
  localparam int BIT_LSR   = 3;
  localparam int BIT_RSR   = 2;
  localparam int BIT_MOD   = 1;
  localparam int BIT_EM    = 0;

  localparam int BIT_LDUM  = 5;
  localparam int BIT_RDUM  = 4;
  localparam int BIT_LMUTE = 1;
  localparam int BIT_RMUTE = 0;

  localparam int BIT_LIVE   = 4;
  localparam int BIT_STICKY = 0;

  localparam logic [DATA_W-1:0] MUTE_RSVD_MASK  = 8'hCC;
  localparam logic [DATA_W-1:0] SHORT_RSVD_MASK = 8'hEE;
  localparam logic [DATA_W-1:0] RSVD_RESET      = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET     = 8'h00;
  localparam logic              FLAG_RESET      = 1'b0;

  function automatic logic [SEL_W-1:0] reg_sel(input logic [ADDR_W-1:0] addr);
    logic [SEL_W-1:0] sel;
    sel = '0;
    case (addr)
      ADDR_POWER: sel[SEL_POWER] = 1'b1;
      ADDR_BIAS:  sel[SEL_BIAS]  = 1'b1;
      ADDR_MUTE:  sel[SEL_MUTE]  = 1'b1;
      ADDR_SHORT: sel[SEL_SHORT] = 1'b1;
      default:    sel = '0;
    endcase
    return sel;
  endfunction

endpackage

// File: include/monitor_if.sv
`timescale 1ns/1ps
`default_nettype none
interface monitor_if;
  import analog_status_monitor_pkg::*;
  logic [DATA_W-1:0] power_q;
  logic [DATA_W-1:0] bias_q;
  logic [MUTE_W-1:0] mute_q;
  logic              short_q;
  logic              sticky_q;
  logic              read_clear;

  modport sampler (output power_q, bias_q, mute_q, short_q);
  modport latch   (input short_q, read_clear, output sticky_q);
  modport regs    (input power_q, bias_q, mute_q, short_q, sticky_q, output read_clear);
endinterface
`default_nettype wire

// File: src/monitor_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module monitor_sampler
  import analog_status_monitor_pkg::*;
(
  input  wire logic                i_clock,  // System clock
  input  wire logic                i_rst_n,  // Async reset, active low
  input  wire logic [SAMPLE_W-1:0] i_raw,    // Live analog status levels
  monitor_if.sampler               mon       // Sampled status out
);

  logic [SAMPLE_W-1:0] nxt_sample;
  logic [SAMPLE_W-1:0] sample_ff;

  // Each status level is captured every clock
  generate
    for (genvar i = 0; i < SAMPLE_W; i++) begin : g_bit
      assign nxt_sample[i] = i_raw[i];
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sample_ff <= '0;
    end else begin
      sample_ff <= nxt_sample;
    end
  end

  assign mon.power_q = sample_ff[SAMPLE_W-1 -: DATA_W];
  assign mon.bias_q  = sample_ff[SAMPLE_W-1-DATA_W -: DATA_W];
  assign mon.mute_q  = sample_ff[MUTE_W:1];
  assign mon.short_q = sample_ff[0];

endmodule
`default_nettype wire

// File: src/sticky_short_latch.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_short_latch
  import analog_status_monitor_pkg::*;
(
  input  wire logic i_clock,  // System clock
  input  wire logic i_rst_n,  // Async reset, active low
  monitor_if.latch  mon       // Live short in, sticky flag out
);

  logic nxt_sticky;
  logic sticky_ff;

  // A short seen in the clearing cycle keeps the flag set
  always_comb begin
    nxt_sticky = mon.short_q | (sticky_ff & ~mon.read_clear);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sticky_ff <= FLAG_RESET;
    end else begin
      sticky_ff <= nxt_sticky;
    end
  end

  assign mon.sticky_q = sticky_ff;

endmodule
`default_nettype wire

// File: src/analog_status_monitor_regs.sv
`timescale 1ns/1ps
`default_nettype none
module analog_status_monitor_regs
  import analog_status_monitor_pkg::*;
(
  input  wire logic              i_clock,                      // 100 MHz clock
  input  wire logic              i_rst_n,                      // Async reset
  input  wire logic [ADDR_W-1:0] i_reg_addr,                   // Register address
  input  wire logic              i_reg_rd,                     // Read strobe
  input  wire logic              i_reg_wr,                     // Write strobe
  input  wire logic [DATA_W-1:0] i_reg_wdata,                  // Write data
  output logic      [DATA_W-1:0] o_reg_rdata,                  // Read data
  output logic                   o_reg_rvalid,                 // Read data valid
  input  wire logic              i_charge_pump_power_flag,     // 1 active
  input  wire logic              i_reference_power_flag,       // 1 active
  input  wire logic              i_line_driver_power_flag,     // 1 active
  input  wire logic              i_line_bias_power_flag,       // 1 active
  input  wire logic              i_line_feedback_power_flag,   // 1 active
  input  wire logic              i_left_output_power_flag,     // 1 active
  input  wire logic              i_right_output_power_flag,    // 1 active
  input  wire logic              i_dac_power_flag,             // 1 active
  input  wire logic              i_offset_comp_power_flag,     // 1 active
  input  wire logic              i_short_protector_power_flag, // 1 active
  input  wire logic              i_impedance_sensor_power_flag,   // 1 active
  input  wire logic              i_impedance_circuit_power_flag,  // 1 active
  input  wire logic              i_left_short_reset_flag,      // 0 in reset
  input  wire logic              i_right_short_reset_flag,     // 0 in reset
  input  wire logic              i_modulator_reset_flag,       // 0 in reset
  input  wire logic              i_element_match_reset_flag,   // 0 in reset
  input  wire logic              i_left_dummy_mute_flag,       // 0 muted
  input  wire logic              i_right_dummy_mute_flag,      // 0 muted
  input  wire logic              i_left_analog_mute_flag,      // 0 muted
  input  wire logic              i_right_analog_mute_flag,     // 0 muted
  input  wire logic              i_live_short_flag             // 1 shorted
);

  monitor_if mon ();

  logic [SAMPLE_W-1:0] raw_status;
  logic [DATA_W-1:0]   power_raw;
  logic [DATA_W-1:0]   bias_raw;
  logic [MUTE_W-1:0]   mute_raw;

  // Live levels gathered in register bit order
  always_comb begin
    power_raw            = '0;
    power_raw[BIT_CP]    = i_charge_pump_power_flag;
    power_raw[BIT_REF]   = i_reference_power_flag;
    power_raw[BIT_LDRV]  = i_line_driver_power_flag;
    power_raw[BIT_LBIAS] = i_line_bias_power_flag;
    power_raw[BIT_LFB]   = i_line_feedback_power_flag;
    power_raw[BIT_LOUT]  = i_left_output_power_flag;
    power_raw[BIT_ROUT]  = i_right_output_power_flag;
    power_raw[BIT_DAC]   = i_dac_power_flag;
    bias_raw             = '0;
    bias_raw[BIT_OFS]    = i_offset_comp_power_flag;
    bias_raw[BIT_SPROT]  = i_short_protector_power_flag;
    bias_raw[BIT_IMPS]   = i_impedance_sensor_power_flag;
    bias_raw[BIT_IMPW]   = i_impedance_circuit_power_flag;
    bias_raw[BIT_LSR]    = i_left_short_reset_flag;
    bias_raw[BIT_RSR]    = i_right_short_reset_flag;
    bias_raw[BIT_MOD]    = i_modulator_reset_flag;
    bias_raw[BIT_EM]     = i_element_match_reset_flag;
    mute_raw = {i_left_dummy_mute_flag, i_right_dummy_mute_flag,
                i_left_analog_mute_flag, i_right_analog_mute_flag};
    raw_status = {power_raw, bias_raw, mute_raw, i_live_short_flag};
  end

  monitor_sampler u_sampler (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_raw   (raw_status),
    .mon     (mon.sampler)
  );

  sticky_short_latch u_sticky (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .mon     (mon.latch)
  );

  logic [SEL_W-1:0] rd_sel;
  logic [SEL_W-1:0] wr_sel;

  always_comb begin
    rd_sel = i_reg_rd ? reg_sel(i_reg_addr) : '0;
    wr_sel = i_reg_wr ? reg_sel(i_reg_addr) : '0;
  end

  // Reading the short byte clears the sticky flag
  assign mon.read_clear = rd_sel[SEL_SHORT];

  // Reserved storage: only reserved bits take write data
  logic [DATA_W-1:0] mute_rsvd_ff;
  logic [DATA_W-1:0] short_rsvd_ff;
  logic [DATA_W-1:0] nxt_mute_rsvd;
  logic [DATA_W-1:0] nxt_short_rsvd;

  always_comb begin
    nxt_mute_rsvd  = mute_rsvd_ff;
    nxt_short_rsvd = short_rsvd_ff;
    if (wr_sel[SEL_MUTE]) begin
      nxt_mute_rsvd = i_reg_wdata & MUTE_RSVD_MASK;
    end
    if (wr_sel[SEL_SHORT]) begin
      nxt_short_rsvd = i_reg_wdata & SHORT_RSVD_MASK;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mute_rsvd_ff  <= RSVD_RESET;
      short_rsvd_ff <= RSVD_RESET;
    end else begin
      mute_rsvd_ff  <= nxt_mute_rsvd;
      short_rsvd_ff <= nxt_short_rsvd;
    end
  end

  // Register views as seen by a read
  logic [DATA_W-1:0] mute_view;
  logic [DATA_W-1:0] short_view;

  always_comb begin
    mute_view            = mute_rsvd_ff;
    mute_view[BIT_LDUM]  = mon.mute_q[3];
    mute_view[BIT_RDUM]  = mon.mute_q[2];
    mute_view[BIT_LMUTE] = mon.mute_q[1];
    mute_view[BIT_RMUTE] = mon.mute_q[0];
    short_view             = short_rsvd_ff;
    short_view[BIT_LIVE]   = mon.short_q;
    short_view[BIT_STICKY] = mon.sticky_q;
  end

  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic              rvalid_ff;
  logic              nxt_rvalid;

  // Unmapped reads answer zero
  always_comb begin
    nxt_rvalid = i_reg_rd;
    nxt_rdata  = rdata_ff;
    if (i_reg_rd) begin
      case (1'b1)
        rd_sel[SEL_POWER]: nxt_rdata = mon.power_q;
        rd_sel[SEL_BIAS]:  nxt_rdata = mon.bias_q;
        rd_sel[SEL_MUTE]:  nxt_rdata = mute_view;
        rd_sel[SEL_SHORT]: nxt_rdata = short_view;
        default:           nxt_rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff  <= RDATA_RESET;
      rvalid_ff <= FLAG_RESET;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign o_reg_rdata  = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;

  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_read_of(logic [ADDR_W-1:0] a);
    i_reg_rd && i_reg_addr == a;
  endsequence

  sequence s_short_read_quiet;
    s_read_of(ADDR_SHORT) ##0 !mon.short_q;
  endsequence

  a_cp_power_bit: assert property (
    s_read_of(ADDR_POWER) |=> o_reg_rvalid
      && o_reg_rdata[BIT_CP] == $past(i_charge_pump_power_flag, 2))
    else $error("charge pump bit wrong");

  a_ref_power_bit: assert property (
    s_read_of(ADDR_POWER) |=>
      o_reg_rdata[BIT_REF] == $past(i_reference_power_flag, 2))
    else $error("reference bit wrong");

  a_line_power_bits: assert property (
    s_read_of(ADDR_POWER) |=> o_reg_rdata[BIT_LDRV:BIT_LFB] ==
      {$past(i_line_driver_power_flag, 2), $past(i_line_bias_power_flag, 2),
       $past(i_line_feedback_power_flag, 2)})
    else $error("line power bits wrong");

  a_stage_power_bits: assert property (
    s_read_of(ADDR_POWER) |=> o_reg_rdata[BIT_LOUT:BIT_ROUT] ==
      {$past(i_left_output_power_flag, 2), $past(i_right_output_power_flag, 2)})
    else $error("output stage bits wrong");

  a_dac_power_bit: assert property (
    s_read_of(ADDR_POWER) |=>
      o_reg_rdata[BIT_DAC] == $past(i_dac_power_flag, 2))
    else $error("dac bit wrong");

  a_ofs_sprot_bits: assert property (
    s_read_of(ADDR_BIAS) |=> o_reg_rdata[BIT_OFS:BIT_SPROT] ==
      {$past(i_offset_comp_power_flag, 2), $past(i_short_protector_power_flag, 2)})
    else $error("offset or protector bit wrong");

  a_impedance_bits: assert property (
    s_read_of(ADDR_BIAS) |=> o_reg_rdata[BIT_IMPS:BIT_IMPW] ==
      {$past(i_impedance_sensor_power_flag, 2),
       $past(i_impedance_circuit_power_flag, 2)})
    else $error("impedance bits wrong");

  a_protector_reset_bits: assert property (
    s_read_of(ADDR_BIAS) |=> o_reg_rdata[BIT_LSR:BIT_RSR] ==
      {$past(i_left_short_reset_flag, 2), $past(i_right_short_reset_flag, 2)})
    else $error("protector reset bits wrong");

  a_dac_reset_bits: assert property (
    s_read_of(ADDR_BIAS) |=> o_reg_rdata[BIT_MOD:BIT_EM] ==
      {$past(i_modulator_reset_flag, 2), $past(i_element_match_reset_flag, 2)})
    else $error("dac reset bits wrong");

  a_dummy_mute_bits: assert property (
    s_read_of(ADDR_MUTE) |=> o_reg_rdata[BIT_LDUM:BIT_RDUM] ==
      {$past(i_left_dummy_mute_flag, 2), $past(i_right_dummy_mute_flag, 2)})
    else $error("dummy mute bits wrong");

  a_analog_mute_bits: assert property (
    s_read_of(ADDR_MUTE) |=> o_reg_rdata[BIT_LMUTE:BIT_RMUTE] ==
      {$past(i_left_analog_mute_flag, 2), $past(i_right_analog_mute_flag, 2)})
    else $error("analog mute bits wrong");

  a_live_short_bit: assert property (
    s_read_of(ADDR_SHORT) |=>
      o_reg_rdata[BIT_LIVE] == $past(i_live_short_flag, 2))
    else $error("live short bit wrong");

  a_sticky_sets: assert property (
    i_live_short_flag ##1 1'b1 |=> mon.sticky_q)
    else $error("sticky flag missed a short");

  a_sticky_clears: assert property (
    s_short_read_quiet |=> !mon.sticky_q)
    else $error("sticky flag not cleared by read");

  a_sticky_holds: assert property (
    mon.sticky_q && !rd_sel[SEL_SHORT] |=> mon.sticky_q)
    else $error("sticky flag dropped without read");

  a_monitor_no_write: assert property (
    i_reg_wr && !i_reg_rd |=> $stable(o_reg_rdata) && !o_reg_rvalid)
    else $error("write disturbed read path");

  a_reserved_masked: assert property (
    ((mute_rsvd_ff & ~MUTE_RSVD_MASK) == '0)
      && ((short_rsvd_ff & ~SHORT_RSVD_MASK) == '0))
    else $error("monitor field took write data");

  a_unmapped_zero: assert property (
    i_reg_rd && reg_sel(i_reg_addr) == '0 |=> o_reg_rdata == RDATA_RESET)
    else $error("unmapped read not zero");

endmodule
`default_nettype wire

// File: verification/analog_status_monitor_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module analog_status_monitor_regs_test
  import analog_status_monitor_pkg::*;
;
  logic              i_clock;
  logic              i_rst_n;
  logic [ADDR_W-1:0] i_reg_addr;
  logic              i_reg_rd;
  logic              i_reg_wr;
  logic [DATA_W-1:0] i_reg_wdata;
  logic [DATA_W-1:0] o_reg_rdata;
  logic              o_reg_rvalid;
  logic [20:0]       st;
  logic [7:0]        mute_rsvd;
  logic [7:0]        short_rsvd;
  int                num_errors;
  int                n_tests;

  analog_status_monitor_regs dut_u (
    .i_clock                       (i_clock),
    .i_rst_n                       (i_rst_n),
    .i_reg_addr                    (i_reg_addr),
    .i_reg_rd                      (i_reg_rd),
    .i_reg_wr                      (i_reg_wr),
    .i_reg_wdata                   (i_reg_wdata),
    .o_reg_rdata                   (o_reg_rdata),
    .o_reg_rvalid                  (o_reg_rvalid),
    .i_charge_pump_power_flag      (st[7]),
    .i_reference_power_flag        (st[6]),
    .i_line_driver_power_flag      (st[5]),
    .i_line_bias_power_flag        (st[4]),
    .i_line_feedback_power_flag    (st[3]),
    .i_left_output_power_flag      (st[2]),
    .i_right_output_power_flag     (st[1]),
    .i_dac_power_flag              (st[0]),
    .i_offset_comp_power_flag      (st[15]),
    .i_short_protector_power_flag  (st[14]),
    .i_impedance_sensor_power_flag (st[13]),
    .i_impedance_circuit_power_flag(st[12]),
    .i_left_short_reset_flag       (st[11]),
    .i_right_short_reset_flag      (st[10]),
    .i_modulator_reset_flag        (st[9]),
    .i_element_match_reset_flag    (st[8]),
    .i_left_dummy_mute_flag        (st[19]),
    .i_right_dummy_mute_flag       (st[18]),
    .i_left_analog_mute_flag       (st[17]),
    .i_right_analog_mute_flag      (st[16]),
    .i_live_short_flag             (st[20])
  );

  always #5 i_clock = ~i_clock;

  // Expected read value of one address for given status and sticky state
  function automatic logic [7:0] exp_of(input logic [7:0] a, input logic stk);
    case (a)
      ADDR_POWER: return st[7:0];
      ADDR_BIAS:  return st[15:8];
      ADDR_MUTE:  return {mute_rsvd[7:6], st[19:18], mute_rsvd[3:2], st[17:16]};
      ADDR_SHORT: return {short_rsvd[7:5], st[20], short_rsvd[3:1], stk};
      default:    return 8'h00;
    endcase
  endfunction

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    mute_rsvd = 8'h00;
    short_rsvd = 8'h00;
    repeat (2) @(posedge i_clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    if (a == ADDR_MUTE) mute_rsvd = d & MUTE_RSVD_MASK;
    if (a == ADDR_SHORT) short_rsvd = d & SHORT_RSVD_MASK;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    n_tests++;
    if (o_reg_rvalid !== 1'b1 || o_reg_rdata !== e) begin
      num_errors++;
      $display("BAD %0t read %h got %h valid %b want %h", $time, a, o_reg_rdata, o_reg_rvalid, e);
    end
    @(posedge i_clock);
    #1;
    n_tests++;
    if (o_reg_rvalid !== 1'b0 || o_reg_rdata !== e) begin
      num_errors++;
      $display("BAD %0t read valid held or data not held, got %h", $time, o_reg_rdata);
    end
  endtask

  task automatic set_st(input logic [20:0] v);
    @(posedge i_clock);
    st <= v;
    repeat (3) @(posedge i_clock);
  endtask

  // Reads the four mapped registers with sticky flag expected clear
  task automatic read_all();
    rd_chk(ADDR_POWER, exp_of(ADDR_POWER, 1'b0));
    rd_chk(ADDR_BIAS, exp_of(ADDR_BIAS, 1'b0));
    rd_chk(ADDR_MUTE, exp_of(ADDR_MUTE, 1'b0));
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b0));
  endtask

  initial begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    logic [20:0] v;
    logic [7:0]  d;
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_rd = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_wdata = 8'h00;
    st = '0;
    mute_rsvd = 8'h00;
    short_rsvd = 8'h00;
    num_errors = 0;
    n_tests = 0;
    void'($urandom(32'h52E5872B));
    do_reset();
    read_all();
    // Walking one over every status input except the live short flag
    for (int i = 0; i < 20; i++) begin
      set_st(21'(1) << i);
      read_all();
    end
    set_st(21'h0FFFFF);
    read_all();
    // Random status with writes to every register in turn
    for (int k = 0; k < 24; k++) begin
      v = 21'($urandom);
      v[20] = 1'b0;
      d = 8'($urandom);
      wr(ADDR_POWER + 8'(k % 4), d);
      set_st(v);
      read_all();
    end
    wr(8'h70, 8'hFF);
    rd_chk(8'h6E, 8'h00);
    rd_chk(8'h69, 8'h00);
    // Short pulse latches the sticky flag, one read clears it
    @(posedge i_clock);
    st[20] <= 1'b1;
    @(posedge i_clock);
    st[20] <= 1'b0;
    repeat (3) @(posedge i_clock);
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b1));
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b0));
    // Persistent short: live bit set, sticky survives reads
    set_st(st | 21'h100000);
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b1));
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b1));
    set_st(st & 21'h0FFFFF);
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b1));
    rd_chk(ADDR_SHORT, exp_of(ADDR_SHORT, 1'b0));
    // Reserved storage set, then cleared by a second reset
    wr(ADDR_MUTE, 8'hFF);
    wr(ADDR_SHORT, 8'hFF);
    read_all();
    do_reset();
    read_all();
    close_out();
  end
endmodule
`default_nettype wire
